//--- core/fcp_core.sv
// Command interpreter of a serial NOR flash: suspend gating, deep power-down,
// volatile/persistent read parameters and drive strength.
// Assumes SCK, CS_N and IO_IN come from the host; the rest is same-clock logic.
`timescale 1ns/1ps

// Operation
// - Array read opcodes, all nine forms, are accepted during any suspend.
// - Page program, quad program, write latch set accepted only in erase suspend.
// - Status read, function read, error clear accepted during any suspend.
// - Soft reset acts only when arm opcode directly precedes reset opcode.
// - Volatile parameter sets and both readbacks accepted during any suspend.
// - All identification reads are accepted during any suspend.
// - Power-down opcode enters low power; writes, programs, erases then ignored.
// - Power-down engages only on CS rise after exactly one full opcode.
// - While powered down only the release opcode is recognised.
// - After release, nothing is accepted until the release delay ends.
// - Release opcode is ignored while a write is in progress.
// - Read register holds burst, dummy and shared pin select fields.
// - Persistent read set updates both copies; volatile set only volatile.
// - Burst values 0-3 are continuous; 4-7 wrap at 8/16/32/64 bytes.
// - Wrapping reads stay inside the aligned burst until CS rises.
// - Without wrap the read address runs on through the whole array.
// - Wrap lasts until rewritten; power-down entry and soft reset reload it from the persistent copy.
// - Extended register holds drive strength with persistent and volatile sets.
// - Drive strength resets to half and reaches down to one eighth.
// - Function register shows program suspend at bit 2, erase at bit 3.
module fcp_core #(
  parameter int ADDR_W = 24
) (
  input  wire logic              CLK_SYS,
  input  wire logic              RESET_N,
  input  wire logic              SCK,
  input  wire logic              CS_N,
  input  wire logic [3:0]        IO_IN,
  input  wire logic              QPI_MODE,
  input  wire logic              WRITE_IN_PROGRESS_FLAG,
  input  wire logic              SUSP_PROGRAM,
  input  wire logic              SUSP_ERASE,
  input  wire logic [7:0]        STATUS_REG,
  input  wire logic [7:0]        FUNC_REG,
  input  wire logic [2:0]        ERR_FLAGS,
  input  wire logic [7:0]        ARRAY_DATA,
  output logic      [3:0]        IO_OUT,
  output logic      [3:0]        IO_OE,
  output logic                   CMD_VALID,
  output logic      [7:0]        CMD_CODE,
  output logic      [ADDR_W-1:0] READ_ADDR,
  output logic                   POWERED_DOWN,
  output logic                   WRAP_ENABLE,
  output logic      [1:0]        BURST_LEN_SEL,
  output logic      [3:0]        DUMMY_CYCLES,
  output logic                   SHARED_PIN_RESET,
  output logic      [2:0]        DRIVE_STRENGTH,
  output logic      [7:0]        PERSIST_READ_PARAMS,
  output logic      [2:0]        PERSIST_DRIVE,
  output logic                   PERSIST_WR,
  output logic                   ERR_CLEAR,
  output logic                   SOFT_RESET
);

  initial begin
    if (ADDR_W < 8 || ADDR_W > 32) $error("fcp_core: ADDR_W must be 8..32");
  end

  // Pin sampling
  logic [5:0] sy;
  logic       sy_sck;
  logic       sy_cs;
  logic [3:0] sy_io;

  fcp_sync #(.WIDTH(6), .RST_VAL(6'h10)) u_sync ( // Chip select idles high
    .clk     (CLK_SYS),
    .reset_n (RESET_N),
    .d       ({SCK, CS_N, IO_IN}),
    .q       (sy)
  );

  assign sy_sck = sy[5];
  assign sy_cs  = sy[4];
  assign sy_io  = sy[3:0];

  logic sck_q;
  logic cs_q;
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      sck_q <= 1'b0;
      cs_q  <= 1'b1;
    end else begin
      sck_q <= sy_sck;
      cs_q  <= sy_cs;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  assign sck_rise = sy_sck & ~sck_q & ~sy_cs;
  assign sck_fall = ~sy_sck & sck_q & ~sy_cs;
  assign cs_rise  = sy_cs & ~cs_q;

  fcp_pkg::fcp_phase_e phase;
  fcp_pkg::fcp_pwr_e   pwr;
  logic [3:0]  bit_cnt;
  logic [2:0]  byte_idx;
  logic [7:0]  rx_sr;
  logic [7:0]  opcode;
  logic [7:0]  data_byte;
  logic [ADDR_W-1:0] addr_sr;
  logic [7:0]  rd_vol;
  logic [2:0]  ods_vol;
  logic        reset_armed;

  // Suspend and power-down admission
  function automatic logic fcp_allowed(input logic [7:0] op, input logic ps,
                                       input logic es, input fcp_pkg::fcp_pwr_e pw,
                                       input logic busy);
    logic ok;
    ok = 1'b0;
    if (pw == fcp_pkg::PW_WAKING) begin
      ok = 1'b0;
    end else if (pw != fcp_pkg::PW_ACTIVE) begin
      ok = (op == fcp_pkg::OP_RELEASE) && !busy;
    end else if (!(ps || es)) begin
      ok = 1'b1;
    end else begin
      case (op)
        fcp_pkg::OP_NORMAL_READ, fcp_pkg::OP_FAST_READ, fcp_pkg::OP_DUAL_IO,
        fcp_pkg::OP_DUAL_OUT, fcp_pkg::OP_QUAD_IO, fcp_pkg::OP_QUAD_OUT,
        fcp_pkg::OP_DDR_FAST, fcp_pkg::OP_DDR_DUAL,
        fcp_pkg::OP_DDR_QUAD: ok = 1'b1;
        fcp_pkg::OP_STATUS_RD, fcp_pkg::OP_FUNC_RD,
        fcp_pkg::OP_ERR_CLEAR: ok = 1'b1;
        fcp_pkg::OP_RESET_ARM, fcp_pkg::OP_RESET_GO: ok = 1'b1;
        fcp_pkg::OP_RP_VOL_A, fcp_pkg::OP_RP_VOL_B, fcp_pkg::OP_XP_VOL,
        fcp_pkg::OP_RP_READ, fcp_pkg::OP_XP_READ: ok = 1'b1;
        fcp_pkg::OP_RELEASE, fcp_pkg::OP_STD_ID, fcp_pkg::OP_STD_ID_Q,
        fcp_pkg::OP_MAKER_ID, fcp_pkg::OP_UNIQUE_ID: ok = 1'b1;
        fcp_pkg::OP_RESUME_A, fcp_pkg::OP_RESUME_B, fcp_pkg::OP_PARAM_TABLE,
        fcp_pkg::OP_NOP, fcp_pkg::OP_INFO_ROW, fcp_pkg::OP_BOOT_RD: ok = 1'b1;
        // A program nested inside an erase suspend closes these again
        fcp_pkg::OP_PAGE_PROG, fcp_pkg::OP_QPROG_A, fcp_pkg::OP_QPROG_B,
        fcp_pkg::OP_WRITE_LATCH: ok = es && !ps;
        fcp_pkg::OP_SUSPEND_A, fcp_pkg::OP_SUSPEND_B, fcp_pkg::OP_SECT_UNPROT,
        fcp_pkg::OP_SECT_PROT: ok = es && !ps;
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction : fcp_allowed

  function automatic logic fcp_is_read(input logic [7:0] op);
    return op == fcp_pkg::OP_NORMAL_READ || op == fcp_pkg::OP_FAST_READ ||
           op == fcp_pkg::OP_DUAL_IO || op == fcp_pkg::OP_DUAL_OUT ||
           op == fcp_pkg::OP_QUAD_IO || op == fcp_pkg::OP_QUAD_OUT ||
           op == fcp_pkg::OP_DDR_FAST || op == fcp_pkg::OP_DDR_DUAL ||
           op == fcp_pkg::OP_DDR_QUAD;
  endfunction : fcp_is_read

  function automatic logic fcp_is_readback(input logic [7:0] op);
    return op == fcp_pkg::OP_STATUS_RD || op == fcp_pkg::OP_FUNC_RD ||
           op == fcp_pkg::OP_RP_READ || op == fcp_pkg::OP_XP_READ;
  endfunction : fcp_is_readback

  // Burst address step: wrap within the aligned burst, else run on
  function automatic logic [ADDR_W-1:0] fcp_next_addr(input logic [ADDR_W-1:0] a,
                                                       input logic wrap,
                                                       input logic [1:0] len);
    logic [ADDR_W-1:0] m;
    logic [ADDR_W-1:0] inc;
    m   = ADDR_W'((32'd8 << len) - 32'd1);
    inc = a + ADDR_W'(1);
    return wrap ? ((a & ~m) | (inc & m)) : inc;
  endfunction : fcp_next_addr

  // Receive path
  logic [3:0] step;
  logic [3:0] bit_sum;
  logic [7:0] next_rx;
  logic       rx_on;
  logic       byte_done;
  logic       accept;

  always_comb begin
    step      = QPI_MODE ? fcp_pkg::QPI_STEP : fcp_pkg::SPI_STEP;
    bit_sum   = bit_cnt + step;
    next_rx   = QPI_MODE ? {rx_sr[3:0], sy_io} : {rx_sr[6:0], sy_io[0]};
    rx_on     = (phase == fcp_pkg::PH_OPCODE) || (phase == fcp_pkg::PH_ADDR) ||
                (phase == fcp_pkg::PH_DATA_IN);
    byte_done = sck_rise && rx_on && (bit_sum == fcp_pkg::BYTE_BITS);
    accept    = fcp_allowed(next_rx, SUSP_PROGRAM, SUSP_ERASE, pwr, WRITE_IN_PROGRESS_FLAG);
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      phase     <= fcp_pkg::PH_OPCODE;
      bit_cnt   <= 4'h0;
      byte_idx  <= 3'h0;
      rx_sr     <= 8'h00;
      opcode    <= 8'h00;
      data_byte <= 8'h00;
      addr_sr   <= '0;
    end else if (sy_cs) begin
      phase    <= fcp_pkg::PH_OPCODE;
      bit_cnt  <= 4'h0;
      byte_idx <= 3'h0;
    end else if (sck_rise && rx_on) begin
      rx_sr   <= next_rx;
      bit_cnt <= byte_done ? 4'h0 : bit_sum;
      if (byte_done) begin
        if (byte_idx != fcp_pkg::BYTE_IDX_MAX) begin
          byte_idx <= byte_idx + 3'h1;
        end
        case (phase)
          fcp_pkg::PH_OPCODE: begin
            opcode <= next_rx;
            if (!accept) begin
              phase <= fcp_pkg::PH_IGNORE;
            end else if (fcp_is_read(next_rx)) begin
              phase <= fcp_pkg::PH_ADDR;
            end else if (fcp_is_readback(next_rx)) begin
              phase <= fcp_pkg::PH_SEND;
            end else begin
              phase <= fcp_pkg::PH_DATA_IN;
            end
          end
          fcp_pkg::PH_ADDR: begin
            addr_sr <= {addr_sr[ADDR_W-9:0], next_rx};
            if (byte_idx == fcp_pkg::LAST_ADDR_BYTE) begin
              phase <= fcp_pkg::PH_SEND;
            end
          end
          default: begin
            if (byte_idx == fcp_pkg::DATA_BYTE_IDX) begin
              data_byte <= next_rx;
            end
          end
        endcase
      end
    end
  end

  // Frame end decisions
  logic frame_ok;
  logic frame_has_data;
  logic dp_frame;
  assign frame_ok       = cs_rise && (byte_idx != 3'h0) && (phase != fcp_pkg::PH_IGNORE);
  assign frame_has_data = frame_ok && (byte_idx > fcp_pkg::DATA_BYTE_IDX);
  // Extra clocks after the opcode cancel power-down entry
  assign dp_frame = frame_ok && (opcode == fcp_pkg::OP_POWER_DOWN) &&
                    (byte_idx == 3'h1) && (bit_cnt == 4'h0);

  // Power-down state
  logic [15:0] pwr_cnt;
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      pwr          <= fcp_pkg::PW_ACTIVE;
      pwr_cnt      <= 16'h0000;
      POWERED_DOWN <= 1'b0;
    end else begin
      case (pwr)
        fcp_pkg::PW_ACTIVE: begin
          if (dp_frame) begin
            pwr          <= fcp_pkg::PW_ENTERING;
            pwr_cnt      <= 16'(fcp_pkg::DP_CYCLES - 1);
            POWERED_DOWN <= 1'b1;
          end
        end
        fcp_pkg::PW_ENTERING: begin
          if (pwr_cnt == 16'h0000) begin
            pwr <= fcp_pkg::PW_DOWN;
          end else begin
            pwr_cnt <= pwr_cnt - 16'h0001;
          end
        end
        fcp_pkg::PW_DOWN: begin
          // Admission already refused the release while busy
          if (frame_ok && opcode == fcp_pkg::OP_RELEASE) begin
            pwr     <= fcp_pkg::PW_WAKING;
            pwr_cnt <= 16'(fcp_pkg::RES_CYCLES - 1);
          end
        end
        default: begin
          if (pwr_cnt == 16'h0000) begin
            pwr          <= fcp_pkg::PW_ACTIVE;
            POWERED_DOWN <= 1'b0;
          end else begin
            pwr_cnt <= pwr_cnt - 16'h0001;
          end
        end
      endcase
    end
  end

  // Soft reset sequencing
  logic reset_fire;
  assign reset_fire = frame_ok && reset_armed && (opcode == fcp_pkg::OP_RESET_GO);

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      reset_armed <= 1'b0;
      SOFT_RESET  <= 1'b0;
    end else begin
      SOFT_RESET <= reset_fire;
      if (frame_ok) begin
        reset_armed <= (opcode == fcp_pkg::OP_RESET_ARM);
      end
    end
  end

  // Parameter registers
  logic dp_done;
  assign dp_done = (pwr == fcp_pkg::PW_ENTERING) && (pwr_cnt == 16'h0000);

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_vol              <= fcp_pkg::READ_PARAMS_RST;
      PERSIST_READ_PARAMS <= fcp_pkg::READ_PARAMS_RST;
      ods_vol             <= fcp_pkg::ODS_RST;
      PERSIST_DRIVE       <= fcp_pkg::ODS_RST;
      PERSIST_WR          <= 1'b0;
    end else begin
      PERSIST_WR <= 1'b0;
      if (reset_fire || dp_done) begin
        rd_vol  <= PERSIST_READ_PARAMS;
        ods_vol <= PERSIST_DRIVE;
      end else if (frame_has_data) begin
        case (opcode)
          fcp_pkg::OP_RP_PERSIST: begin
            rd_vol              <= data_byte;
            PERSIST_READ_PARAMS <= data_byte;
            PERSIST_WR          <= 1'b1;
          end
          fcp_pkg::OP_RP_VOL_A, fcp_pkg::OP_RP_VOL_B: begin
            rd_vol <= data_byte;
          end
          fcp_pkg::OP_XP_PERSIST: begin
            ods_vol       <= data_byte[7:5];
            PERSIST_DRIVE <= data_byte[7:5];
            PERSIST_WR    <= 1'b1;
          end
          fcp_pkg::OP_XP_VOL: begin
            ods_vol <= data_byte[7:5];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Field views of the volatile copies
  assign WRAP_ENABLE      = rd_vol[fcp_pkg::RP_WRAP_BIT];
  assign BURST_LEN_SEL    = rd_vol[fcp_pkg::RP_BURST_LSB +: 2];
  assign DUMMY_CYCLES     = rd_vol[fcp_pkg::RP_DUMMY_LSB +: 4];
  assign SHARED_PIN_RESET = rd_vol[fcp_pkg::RP_PIN_BIT];
  assign DRIVE_STRENGTH   = ods_vol;

  // Command forwarding
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      CMD_VALID <= 1'b0;
      CMD_CODE  <= 8'h00;
      ERR_CLEAR <= 1'b0;
    end else begin
      CMD_VALID <= byte_done && (phase == fcp_pkg::PH_OPCODE) && accept;
      if (byte_done && (phase == fcp_pkg::PH_OPCODE) && accept) begin
        CMD_CODE <= next_rx;
      end
      ERR_CLEAR <= frame_ok && (opcode == fcp_pkg::OP_ERR_CLEAR);
    end
  end

  // Transmit path
  logic [7:0] tx_byte;
  logic [7:0] tx_sr;
  logic [2:0] tx_cnt;

  always_comb begin
    case (opcode)
      fcp_pkg::OP_STATUS_RD: tx_byte = STATUS_REG;
      fcp_pkg::OP_FUNC_RD: begin
        tx_byte = FUNC_REG;
        tx_byte[fcp_pkg::FR_PROGRAM_SUSPENDED_FLAG_BIT] = SUSP_PROGRAM;
        tx_byte[fcp_pkg::FR_ERASE_SUSPENDED_FLAG_BIT] = SUSP_ERASE;
      end
      fcp_pkg::OP_RP_READ: tx_byte = rd_vol;
      fcp_pkg::OP_XP_READ: tx_byte = {ods_vol, 1'b0, ERR_FLAGS, WRITE_IN_PROGRESS_FLAG};
      default: tx_byte = ARRAY_DATA;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      IO_OUT    <= 4'h0;
      IO_OE     <= 4'h0;
      tx_sr     <= 8'h00;
      tx_cnt    <= 3'h0;
      READ_ADDR <= '0;
    end else if (sy_cs) begin
      IO_OE  <= 4'h0; // Released as soon as the frame ends
      tx_cnt <= 3'h0;
    end else if (phase == fcp_pkg::PH_ADDR && byte_done &&
                 byte_idx == fcp_pkg::LAST_ADDR_BYTE) begin
      READ_ADDR <= {addr_sr[ADDR_W-9:0], next_rx};
    end else if (sck_fall && phase == fcp_pkg::PH_SEND) begin
      if (tx_cnt == 3'h0) begin
        if (QPI_MODE) begin
          IO_OUT <= tx_byte[7:4];
          IO_OE  <= 4'hf;
          tx_sr  <= {tx_byte[3:0], 4'h0};
          tx_cnt <= 3'h1;
        end else begin
          IO_OUT <= {2'b00, tx_byte[7], 1'b0};
          IO_OE  <= 4'h2;
          tx_sr  <= {tx_byte[6:0], 1'b0};
          tx_cnt <= 3'h7;
        end
        if (fcp_is_read(opcode)) begin
          READ_ADDR <= fcp_next_addr(READ_ADDR, WRAP_ENABLE, BURST_LEN_SEL);
        end
      end else begin
        IO_OUT <= QPI_MODE ? tx_sr[7:4] : {2'b00, tx_sr[7], 1'b0};
        tx_sr  <= QPI_MODE ? {tx_sr[3:0], 4'h0} : {tx_sr[6:0], 1'b0};
        tx_cnt <= tx_cnt - 3'h1;
      end
    end
  end

endmodule : fcp_core

//--- include/fcp_pkg.sv
// Constants shared by the flash command, power-down and read-parameter logic.
// Assumes a 10 MHz system clock; all link pins are sampled, not clocked on.
package fcp_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_DP_NS       = 3000;
  localparam int T_RES1_NS     = 5000;
  // Entry is a longest time: round down. Release is a least time: round up.
  localparam int DP_CYCLES_RAW = T_DP_NS / CLK_PERIOD_NS;
  localparam int DP_CYCLES     = (DP_CYCLES_RAW < 1) ? 1 : DP_CYCLES_RAW;
  localparam int RES_CYCLES    = (T_RES1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Frame bit counting
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] QPI_STEP  = 4'h4;
  localparam logic [3:0] SPI_STEP  = 4'h1;
  localparam logic [2:0] LAST_ADDR_BYTE = 3'h3;
  localparam logic [2:0] DATA_BYTE_IDX  = 3'h1;
  localparam logic [2:0] BYTE_IDX_MAX   = 3'h7;

  // Read register fields
  localparam int RP_BURST_LSB = 0;
  localparam int RP_WRAP_BIT  = 2;
  localparam int RP_DUMMY_LSB = 3;
  localparam int RP_PIN_BIT   = 7;
  localparam logic [7:0] READ_PARAMS_RST = 8'h00;
  // Drive strength codes
  localparam logic [2:0] ODS_HALF   = 3'h5;
  localparam logic [2:0] ODS_EIGHTH = 3'h1;
  localparam logic [2:0] ODS_RST    = ODS_HALF;
  // Function register suspend flags
  localparam int FR_PROGRAM_SUSPENDED_FLAG_BIT = 2;
  localparam int FR_ERASE_SUSPENDED_FLAG_BIT = 3;

  // Opcodes
  localparam logic [7:0] OP_NORMAL_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ   = 8'h0b;
  localparam logic [7:0] OP_DUAL_IO     = 8'hbb;
  localparam logic [7:0] OP_DUAL_OUT    = 8'h3b;
  localparam logic [7:0] OP_QUAD_IO     = 8'heb;
  localparam logic [7:0] OP_QUAD_OUT    = 8'h6b;
  localparam logic [7:0] OP_DDR_FAST    = 8'h0d;
  localparam logic [7:0] OP_DDR_DUAL    = 8'hbd;
  localparam logic [7:0] OP_DDR_QUAD    = 8'hed;
  localparam logic [7:0] OP_PAGE_PROG   = 8'h02;
  localparam logic [7:0] OP_QPROG_A     = 8'h32;
  localparam logic [7:0] OP_QPROG_B     = 8'h38;
  localparam logic [7:0] OP_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OP_STATUS_RD   = 8'h05;
  localparam logic [7:0] OP_FUNC_RD     = 8'h48;
  localparam logic [7:0] OP_ERR_CLEAR   = 8'h82;
  localparam logic [7:0] OP_RESUME_A    = 8'h7a;
  localparam logic [7:0] OP_RESUME_B    = 8'h30;
  localparam logic [7:0] OP_SUSPEND_A   = 8'h75;
  localparam logic [7:0] OP_SUSPEND_B   = 8'hb0;
  localparam logic [7:0] OP_RELEASE     = 8'hab;
  localparam logic [7:0] OP_POWER_DOWN  = 8'hb9;
  localparam logic [7:0] OP_RP_PERSIST  = 8'h65;
  localparam logic [7:0] OP_RP_VOL_A    = 8'hc0;
  localparam logic [7:0] OP_RP_VOL_B    = 8'h63;
  localparam logic [7:0] OP_XP_PERSIST  = 8'h85;
  localparam logic [7:0] OP_XP_VOL      = 8'h83;
  localparam logic [7:0] OP_RP_READ     = 8'h61;
  localparam logic [7:0] OP_XP_READ     = 8'h81;
  localparam logic [7:0] OP_STD_ID      = 8'h9f;
  localparam logic [7:0] OP_STD_ID_Q    = 8'haf;
  localparam logic [7:0] OP_MAKER_ID    = 8'h90;
  localparam logic [7:0] OP_UNIQUE_ID   = 8'h4b;
  localparam logic [7:0] OP_PARAM_TABLE = 8'h5a;
  localparam logic [7:0] OP_NOP         = 8'h00;
  localparam logic [7:0] OP_RESET_ARM   = 8'h66;
  localparam logic [7:0] OP_RESET_GO    = 8'h99;
  localparam logic [7:0] OP_INFO_ROW    = 8'h68;
  localparam logic [7:0] OP_SECT_UNPROT = 8'h26;
  localparam logic [7:0] OP_SECT_PROT   = 8'h24;
  localparam logic [7:0] OP_BOOT_RD     = 8'h14;

  typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_DATA_IN, PH_SEND, PH_IGNORE} fcp_phase_e;
  typedef enum logic [1:0] {PW_ACTIVE, PW_ENTERING, PW_DOWN, PW_WAKING} fcp_pwr_e;

endpackage : fcp_pkg

//--- core/fcp_sync.sv
// Two-stage synchroniser for a group of independent level inputs.
// Assumes each bit is sampled on its own; no bus coherence is implied.
`timescale 1ns/1ps
module fcp_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  initial begin
    if (WIDTH < 1) $error("fcp_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : fcp_sync

//--- bench/fcp_monitor.sv
// Port checker for the flash command core.
// Assumes it is bound to fcp_core; one clock domain, async active-low reset.
`timescale 1ns/1ps
module fcp_monitor (
  input wire logic       CLK_SYS,
  input wire logic       RESET_N,
  input wire logic       CS_N,
  input wire logic       SUSP_PROGRAM,
  input wire logic       SUSP_ERASE,
  input wire logic       CMD_VALID,
  input wire logic [7:0] CMD_CODE,
  input wire logic       POWERED_DOWN,
  input wire logic       WRAP_ENABLE,
  input wire logic [1:0] BURST_LEN_SEL,
  input wire logic [3:0] DUMMY_CYCLES,
  input wire logic       SHARED_PIN_RESET,
  input wire logic [2:0] DRIVE_STRENGTH,
  input wire logic [7:0] PERSIST_READ_PARAMS,
  input wire logic [2:0] PERSIST_DRIVE,
  input wire logic       PERSIST_WR,
  input wire logic       SOFT_RESET
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  logic [7:0] down_cnt;
  // Saturates so a long stay powered down never wraps to a small count
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) down_cnt <= 8'h00;
    else if (!POWERED_DOWN || !CS_N) down_cnt <= 8'h00;
    else if (down_cnt != 8'hff) down_cnt <= down_cnt + 8'h01;
  end
  a_prog_susp_gate: assert property (CMD_VALID && SUSP_PROGRAM |-> !(CMD_CODE inside
    {8'h02, 8'h32, 8'h38, 8'h06})) else $error("Write opcode taken in program suspend");
  a_susp_ignore: assert property ((SUSP_PROGRAM || SUSP_ERASE) && CMD_VALID |->
    !(CMD_CODE inside {8'hb9, 8'h65, 8'h85})) else $error("Opcode taken in suspend");
  a_down_release_only: assert property (CMD_VALID && POWERED_DOWN |->
    CMD_CODE == fcp_pkg::OP_RELEASE) else $error("Opcode taken while powered down");
  a_down_no_write: assert property (POWERED_DOWN |-> !PERSIST_WR)
    else $error("Persistent write while powered down");
  a_pd_entry: assert property ($rose(POWERED_DOWN) |-> CS_N && $past(CS_N, 2) &&
    CMD_CODE == fcp_pkg::OP_POWER_DOWN) else $error("Power-down without framed opcode");
  a_release_wait: assert property ($fell(POWERED_DOWN) |->
    int'(down_cnt) >= fcp_pkg::RES_CYCLES) else $error("Release delay too short");
  a_read_persist: assert property ($changed(PERSIST_READ_PARAMS) |-> PERSIST_WR &&
    {SHARED_PIN_RESET, DUMMY_CYCLES, WRAP_ENABLE, BURST_LEN_SEL} == PERSIST_READ_PARAMS)
    else $error("Persistent read set did not update both copies");
  a_drive_persist: assert property ($changed(PERSIST_DRIVE) |-> PERSIST_WR &&
    DRIVE_STRENGTH == PERSIST_DRIVE) else $error("Persistent drive set mismatch");
  a_soft_reset_pair: assert property (SOFT_RESET |->
    CMD_CODE == fcp_pkg::OP_RESET_GO) else $error("Soft reset without reset opcode");
endmodule : fcp_monitor

//--- bench/fcp_host.sv
// Host controller model: frames opcodes and data on the serial link.
// Assumes mode 0 with an 800 ns clock; reads data late in the high phase.
`timescale 1ns/1ps
module fcp_host (
  input  wire logic       qpi,
  input  wire logic [3:0] io_out,
  output logic            sck,
  output logic            cs_n,
  output logic      [3:0] io_in
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h0;
  end
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 0; i < (qpi ? 2 : 8); i++) begin
      io_in = qpi ? b[7:4] : {~io_in[3:1], b[7]};
      b = qpi ? {b[3:0], 4'h0} : {b[6:0], 1'b0};
      #400 sck = 1'b1;
      // Device answers a few system clocks after each fall, so sample late
      #390 r = qpi ? {r[3:0], io_out} : {r[6:0], io_out[1]};
      #10 sck = 1'b0;
    end
  endtask : xfer
  task automatic frame(input logic [31:0] tx, input int n_tx, input int n_rx,
                       output logic [23:0] rx);
    logic [7:0] r;
    // Start on a falling system clock edge so no pin moves on a sampling edge
    #((100 - $time % 100) % 100);
    rx = 24'h0;
    cs_n = 1'b0;
    for (int i = 0; i < n_tx + n_rx; i++) begin
      xfer(i < n_tx ? tx[31-8*i -: 8] : 8'h00, r);
      if (i >= n_tx) rx = {rx[15:0], r};
    end
    #400 cs_n = 1'b1;
    // Released lines show the inverse of the last value
    io_in = ~io_in;
    #1600;
  endtask : frame
endmodule : fcp_host

//--- bench/tb.sv
// Self-checking bench for the flash command core.
// Assumes fcp_core, the host link model and the port checker.
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        qpi = 1'b0;
  logic        write_in_progress_flag = 1'b0;
  logic        sp = 1'b0;
  logic        se = 1'b0;
  logic        sck, cs_n, cv, pd, wrap, pin, pwr, ecl, srst;
  logic [3:0]  io_in, io_out, io_oe, dum;
  logic [7:0]  code, prp;
  logic [23:0] addr, rx;
  logic [1:0]  blen;
  logic [2:0]  drv, pdrv;
  int          errors = 0;
  int          n_checks = 0;
  int          ncmd = 0;
  int          nsr = 0;
  int          necl = 0;
  logic [3:0]  oe = 4'h0;
  logic [7:0]  ops [21] = '{8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b, 8'h0d, 8'hbd, 8'hed,
    8'h05, 8'h48, 8'h82, 8'hc0, 8'h63, 8'h83, 8'h61, 8'h81, 8'h9f, 8'h90, 8'haf, 8'h4b};
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    if (cv === 1'b1) ncmd++;
    if (srst === 1'b1) nsr++;
    if (ecl === 1'b1) necl++;
    if (io_oe !== 4'h0) oe = io_oe;
  end
  fcp_core DUT (
    .CLK_SYS(clk), .RESET_N(rst_n), .SCK(sck), .CS_N(cs_n), .IO_IN(io_in),
    .QPI_MODE(qpi), .WRITE_IN_PROGRESS_FLAG(write_in_progress_flag), .SUSP_PROGRAM(sp), .SUSP_ERASE(se),
    .STATUS_REG(8'h00), .FUNC_REG(8'h08), .ERR_FLAGS(3'h5), .ARRAY_DATA(addr[7:0]),
    .IO_OUT(io_out), .IO_OE(io_oe), .CMD_VALID(cv), .CMD_CODE(code), .READ_ADDR(addr),
    .POWERED_DOWN(pd), .WRAP_ENABLE(wrap), .BURST_LEN_SEL(blen), .DUMMY_CYCLES(dum),
    .SHARED_PIN_RESET(pin), .DRIVE_STRENGTH(drv), .PERSIST_READ_PARAMS(prp),
    .PERSIST_DRIVE(pdrv), .PERSIST_WR(pwr), .ERR_CLEAR(ecl), .SOFT_RESET(srst));
  fcp_host u_host (.qpi(qpi), .io_out(io_out), .sck(sck), .cs_n(cs_n), .io_in(io_in));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [7:0] op, input logic [7:0] d, input int n);
    u_host.frame({op, d, 16'h0000}, n, 0, rx);
  endtask : send
  task automatic print_verdict();
    $display("Checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  initial begin
    #5000000;
    errors++;
    print_verdict();
  end
  initial begin
    int n0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({drv, prp, wrap}, {fcp_pkg::ODS_HALF, 9'h000});
    @(posedge clk) sp <= 1'b1;
    n0 = ncmd;
    foreach (ops[i]) send(ops[i], 8'h03, 2);
    chk(ncmd - n0, 21);
    chk(drv, 3'h0);
    chk(necl, 1);
    u_host.frame({8'h48, 24'h0}, 1, 1, rx);
    chk(rx[7:0], 8'h04);
    n0 = ncmd;
    send(8'h06, 8'h00, 1);
    send(8'h02, 8'h00, 1);
    send(8'hb9, 8'h00, 1);
    send(8'h65, 8'h80, 2);
    chk(ncmd - n0, 0);
    chk({pd, prp}, 9'h000);
    @(posedge clk) sp <= 1'b0;
    se <= 1'b1;
    n0 = ncmd;
    send(8'h06, 8'h00, 1);
    send(8'h38, 8'h00, 1);
    chk(ncmd - n0, 2);
    send(8'h66, 8'h00, 1);
    send(8'h99, 8'h00, 1);
    send(8'h99, 8'h00, 1);
    chk(nsr, 1);
    chk(drv, fcp_pkg::ODS_HALF);
    @(posedge clk) se <= 1'b0;
    send(8'hc0, 8'hf6, 2);
    chk({prp, pin, dum, wrap, blen}, 16'h00f6);
    send(8'h65, 8'h05, 2);
    chk({prp, pin, dum, wrap, blen}, 16'h0505);
    send(8'h83, 8'h20, 2);
    chk({drv, pdrv}, 6'h0d);
    send(8'h85, 8'h40, 2);
    chk({drv, pdrv}, 6'h12);
    @(posedge clk) qpi <= 1'b1;
    u_host.frame({8'h61, 24'h0}, 1, 1, rx);
    chk({oe, rx[7:0]}, 12'hf05);
    @(posedge clk) qpi <= 1'b0;
    u_host.frame({8'h81, 24'h0}, 1, 1, rx);
    chk({oe, rx[7:0]}, 12'h24a);
    send(8'h63, 8'h04, 2);
    u_host.frame({8'h0b, 24'h0000fe}, 4, 3, rx);
    chk(rx, 24'hfefff8);
    send(8'hc0, 8'h00, 2);
    u_host.frame({8'h03, 24'h0000ff}, 4, 2, rx);
    chk(rx[15:0], 16'hff00);
    send(8'hb9, 8'h00, 1);
    n0 = ncmd;
    send(8'h05, 8'h00, 1);
    send(8'h65, 8'h07, 2);
    chk({pd, prp, wrap}, 10'h20b);
    chk(ncmd - n0, 0);
    @(posedge clk) write_in_progress_flag <= 1'b1;
    send(8'hab, 8'h00, 1);
    repeat (60) @(posedge clk);
    chk(pd, 1'b1);
    write_in_progress_flag <= 1'b0;
    send(8'hab, 8'h00, 1);
    // Chip select stays high through the release delay
    repeat (fcp_pkg::RES_CYCLES - 20) @(posedge clk);
    chk(pd, 1'b1);
    repeat (30) @(posedge clk);
    chk(pd, 1'b0);
    print_verdict();
  end
endmodule : tb
bind fcp_core fcp_monitor u_mon (.CLK_SYS, .RESET_N, .CS_N, .SUSP_PROGRAM, .SUSP_ERASE,
  .CMD_VALID, .CMD_CODE, .POWERED_DOWN, .WRAP_ENABLE, .BURST_LEN_SEL, .DUMMY_CYCLES,
  .SHARED_PIN_RESET, .DRIVE_STRENGTH, .PERSIST_READ_PARAMS, .PERSIST_DRIVE,
  .PERSIST_WR, .SOFT_RESET);
